// ==== hw/config_store_array.sv ====
// Seven coded words of configuration storage with fault injection.
`timescale 1ns/1ns
module config_store_array (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic write_en,
  input wire logic [2:0] word_idx,
  input wire logic [tdc_read_pkg::CODE_W-1:0] write_code,
  output logic [tdc_read_pkg::CODE_W-1:0] read_code,
  input wire logic inject_en,
  input wire logic [2:0] inject_idx,
  input wire logic [tdc_read_pkg::CODE_W-1:0] inject_mask
);
  logic [tdc_read_pkg::CODE_W-1:0] cell_q [tdc_read_pkg::CFG_WORDS];

  // An all-zero word is a valid code word, so reset leaves no error.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < tdc_read_pkg::CFG_WORDS; i++) begin
        cell_q[i] <= '0;
      end
    end else if (write_en) begin
      cell_q[word_idx] <= write_code;
    end else if (inject_en && inject_idx <= tdc_read_pkg::LAST_WORD) begin
      cell_q[inject_idx] <= cell_q[inject_idx] ^ inject_mask;
    end
  end

  assign read_code = (word_idx <= tdc_read_pkg::LAST_WORD) ?
    cell_q[word_idx] : '0;
endmodule

// ==== hw/result_status_config_store.sv ====
// Read register bank, serial opcode engine and coded configuration store.
`timescale 1ns/1ns
module result_status_config_store #(
  parameter int STORE_WRITE_CYCLES =
    tdc_read_pkg::STORE_WRITE_US * tdc_read_pkg::CLOCK_MHZ,
  parameter int WORD_WRITE_CYCLES =
    STORE_WRITE_CYCLES / tdc_read_pkg::CFG_WORDS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ssn,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic result_wr,
  input wire logic [1:0] result_idx,
  input wire tdc_read_pkg::result_in_t result_in,
  input wire tdc_read_pkg::front_status_t front_status,
  output logic [1:0] refclk_divider,
  output logic [2:0] tref_divide_by,
  output logic store_busy,
  output logic store_done,
  output logic store_irq,
  input wire logic inject_en,
  input wire logic [2:0] inject_idx,
  input wire logic [tdc_read_pkg::CODE_W-1:0] inject_mask
);
  logic [31:0] result_q [tdc_read_pkg::RESULT_COUNT];
  logic [31:0] cfg_q [tdc_read_pkg::CFG_WORDS];
  logic sck_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] byte_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] op_q;
  logic reading_q;
  logic [tdc_read_pkg::TX_W-1:0] tx_q;
  logic [tdc_read_pkg::TX_W-1:0] read_word;
  logic [7:0] rx_next;
  logic fall;
  logic byte_done;
  logic op_byte;
  logic is_write_op;
  logic [1:0] wr_lane;
  logic [15:0] status_word;
  tdc_read_pkg::store_state_t state_q;
  tdc_read_pkg::store_act_t act_q;
  logic [2:0] idx_q;
  logic [31:0] wait_q;
  logic [31:0] fix_q;
  logic mismatch_q;
  logic single_acc_q;
  logic multi_acc_q;
  logic single_q;
  logic multi_q;
  logic equal_q;
  logic start;
  tdc_read_pkg::store_act_t start_act;
  logic load_word;
  logic nvm_we;
  logic [31:0] enc_in;
  logic [tdc_read_pkg::CODE_W-1:0] enc_code;
  logic [tdc_read_pkg::CODE_W-1:0] rd_code;
  logic [31:0] dec_data;
  logic dec_single;
  logic dec_multi;

  // Shapes a front-end result into the stored register format.
  function automatic logic [31:0] format_result(
    input tdc_read_pkg::result_in_t r
  );
    if (r.mode == tdc_read_pkg::MEAS_MODE1 && !r.calibrated) begin
      format_result = {r.raw_count, tdc_read_pkg::LOW_ZERO};
    end else if (r.mode == tdc_read_pkg::MEAS_MODE1 && r.alu_overflow) begin
      format_result = tdc_read_pkg::ALL_ONES;
    end else begin
      format_result = r.fixed_value;
    end
  endfunction

  // Result registers are loaded by the measurement front end.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < tdc_read_pkg::RESULT_COUNT; i++) begin
        result_q[i] <= '0;
      end
    end else if (result_wr) begin
      result_q[result_idx] <= format_result(result_in);
    end
  end

  // Status word assembled from front-end state and held store flags.
  assign status_word = {equal_q, multi_q, single_q,
    front_status.sensor_short, front_status.sensor_open,
    front_status.precount_timeout, front_status.tdc_timeout,
    front_status.hits_ch2, front_status.hits_ch1,
    1'b0, front_status.result_pointer};

  // Serial framing: bits are taken on the falling clock edge.
  assign fall = sck_q && !sck && !ssn;
  assign rx_next = {rx_q[6:0], si};
  assign byte_done = fall && bit_cnt_q == tdc_read_pkg::LAST_BIT;
  assign op_byte = byte_done && byte_cnt_q == '0;
  assign is_write_op = (op_q & tdc_read_pkg::OP_ADDR_MASK) ==
    tdc_read_pkg::OP_WRITE_BASE && op_q[2:0] <= tdc_read_pkg::LAST_WORD;
  assign wr_lane = 2'(tdc_read_pkg::BYTES_RESULT - byte_cnt_q);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end

  // Select deselect resets the framing, so each access stands alone.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q <= '0;
      byte_cnt_q <= '0;
      rx_q <= '0;
      op_q <= '0;
    end else if (ssn) begin
      bit_cnt_q <= '0;
      byte_cnt_q <= '0;
      op_q <= '0;
    end else if (fall) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_next;
      if (op_byte) begin
        op_q <= rx_next;
      end
      if (byte_done && byte_cnt_q != tdc_read_pkg::BYTE_CNT_MAX) begin
        byte_cnt_q <= byte_cnt_q + 4'h1;
      end
    end
  end

  // Read data is left aligned; bytes past the register width read zero.
  always_comb begin
    read_word = '0;
    if (rx_next == tdc_read_pkg::OP_IDENT) begin
      for (int i = 0; i < tdc_read_pkg::CFG_WORDS; i++) begin
        read_word[tdc_read_pkg::TX_W-1-8*i -: 8] =
          cfg_q[i][tdc_read_pkg::IDENT_LSB +: 8];
      end
    end else if (rx_next[2:0] == tdc_read_pkg::ADR_STATUS) begin
      read_word[tdc_read_pkg::TX_W-1 -: 16] = status_word;
    end else if (rx_next[2:0] == tdc_read_pkg::ADR_ECHO) begin
      read_word[tdc_read_pkg::TX_W-1 -: 8] =
        cfg_q[tdc_read_pkg::ECHO_REG][tdc_read_pkg::ECHO_LSB +: 8];
    end else if (rx_next[2:0] < tdc_read_pkg::ADR_STATUS) begin
      read_word[tdc_read_pkg::TX_W-1 -: 32] =
        result_q[rx_next[1:0]];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= '0;
      reading_q <= 1'b0;
    end else if (ssn) begin
      tx_q <= '0;
      reading_q <= 1'b0;
    end else if (op_byte) begin
      reading_q <= (rx_next & tdc_read_pkg::OP_ADDR_MASK) ==
        tdc_read_pkg::OP_READ_BASE;
      tx_q <= read_word;
    end else if (fall && reading_q) begin
      tx_q <= {tx_q[tdc_read_pkg::TX_W-2:0], 1'b0};
    end
  end

  assign so = tx_q[tdc_read_pkg::TX_W-1];
  assign so_oe_n = !(reading_q && !ssn);

  // Configuration registers: serial writes, or words loaded from the store.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < tdc_read_pkg::CFG_WORDS; i++) begin
        cfg_q[i] <= '0;
      end
    end else if (load_word) begin
      cfg_q[idx_q] <= dec_data;
    end else if (byte_done && is_write_op && byte_cnt_q != '0 &&
                 byte_cnt_q <= tdc_read_pkg::BYTES_RESULT) begin
      cfg_q[op_q[2:0]][wr_lane*8 +: 8] <= rx_next;
    end
  end

  // Divider setting picks the reference unit of calibrated results.
  assign refclk_divider =
    cfg_q[tdc_read_pkg::DIV_REG][tdc_read_pkg::DIV_LSB +: 2];
  always_comb begin
    case (refclk_divider)
      2'h0: tref_divide_by = tdc_read_pkg::DIV_BY_1;
      2'h1: tref_divide_by = tdc_read_pkg::DIV_BY_2;
      default: tref_divide_by = tdc_read_pkg::DIV_BY_4;
    endcase
  end

  // Store actions start only from an opcode byte while the store is idle.
  always_comb begin
    case (rx_next)
      tdc_read_pkg::OP_SAVE: start_act = tdc_read_pkg::ACT_SAVE;
      tdc_read_pkg::OP_LOAD: start_act = tdc_read_pkg::ACT_LOAD;
      default: start_act = tdc_read_pkg::ACT_COMPARE;
    endcase
  end
  assign start = op_byte && state_q == tdc_read_pkg::S_IDLE &&
    (rx_next == tdc_read_pkg::OP_SAVE || rx_next == tdc_read_pkg::OP_LOAD ||
     rx_next == tdc_read_pkg::OP_COMPARE);

  assign load_word = state_q == tdc_read_pkg::S_READ &&
    act_q == tdc_read_pkg::ACT_LOAD;
  assign nvm_we = state_q == tdc_read_pkg::S_WRITE && wait_q <= 32'h1;
  assign enc_in = (act_q == tdc_read_pkg::ACT_SAVE) ? cfg_q[idx_q] : fix_q;

  secded_codec u_codec (
    .enc_data(enc_in),
    .enc_code(enc_code),
    .dec_code(rd_code),
    .dec_data(dec_data),
    .dec_single(dec_single),
    .dec_multi(dec_multi)
  );

  config_store_array u_store (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_en(nvm_we),
    .word_idx(idx_q),
    .write_code(enc_code),
    .read_code(rd_code),
    .inject_en(inject_en),
    .inject_idx(inject_idx),
    .inject_mask(inject_mask)
  );

  // Store sequencer walks the seven words one at a time.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= tdc_read_pkg::S_IDLE;
      act_q <= tdc_read_pkg::ACT_SAVE;
      idx_q <= '0;
      wait_q <= '0;
      fix_q <= '0;
      mismatch_q <= 1'b0;
      single_acc_q <= 1'b0;
      multi_acc_q <= 1'b0;
    end else begin
      case (state_q)
        tdc_read_pkg::S_IDLE: begin
          if (start) begin
            act_q <= start_act;
            idx_q <= '0;
            mismatch_q <= 1'b0;
            single_acc_q <= 1'b0;
            multi_acc_q <= 1'b0;
            wait_q <= 32'(WORD_WRITE_CYCLES);
            state_q <= (start_act == tdc_read_pkg::ACT_SAVE) ?
              tdc_read_pkg::S_WRITE : tdc_read_pkg::S_READ;
          end
        end
        tdc_read_pkg::S_READ: begin
          fix_q <= dec_data;
          single_acc_q <= single_acc_q || dec_single;
          multi_acc_q <= multi_acc_q || dec_multi;
          mismatch_q <= mismatch_q || dec_data != cfg_q[idx_q];
          if (dec_single) begin
            wait_q <= 32'(WORD_WRITE_CYCLES);
            state_q <= tdc_read_pkg::S_WRITE;
          end else if (idx_q == tdc_read_pkg::LAST_WORD) begin
            state_q <= tdc_read_pkg::S_DONE;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        tdc_read_pkg::S_WRITE: begin
          wait_q <= wait_q - 32'h1;
          if (nvm_we) begin
            if (idx_q == tdc_read_pkg::LAST_WORD) begin
              state_q <= tdc_read_pkg::S_DONE;
            end else begin
              idx_q <= idx_q + 3'h1;
              wait_q <= 32'(WORD_WRITE_CYCLES);
              state_q <= (act_q == tdc_read_pkg::ACT_SAVE) ?
                tdc_read_pkg::S_WRITE : tdc_read_pkg::S_READ;
            end
          end
        end
        tdc_read_pkg::S_DONE: begin
          state_q <= tdc_read_pkg::S_IDLE;
        end
        default: begin
          state_q <= tdc_read_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Store flags change only when a load or compare finishes.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      single_q <= 1'b0;
      multi_q <= 1'b0;
      equal_q <= 1'b0;
    end else if (state_q == tdc_read_pkg::S_DONE &&
                 act_q != tdc_read_pkg::ACT_SAVE) begin
      single_q <= single_acc_q;
      multi_q <= multi_acc_q;
      if (act_q == tdc_read_pkg::ACT_COMPARE) begin
        equal_q <= !mismatch_q && !multi_acc_q;
      end
    end
  end

  assign store_busy = state_q != tdc_read_pkg::S_IDLE;
  assign store_done = state_q == tdc_read_pkg::S_DONE;
  assign store_irq = store_done &&
    cfg_q[tdc_read_pkg::IRQ_REG][tdc_read_pkg::IRQ_BIT];

  AST_STATUS_READ: assert property (@(posedge clock) disable iff (sys_rst)
    op_byte && rx_next == {5'b10110, tdc_read_pkg::ADR_STATUS}
    |=> tx_q[55:40] == $past(status_word) && tx_q[39:0] == '0)
    else $error("status read not loaded as two bytes");
  AST_ECHO_READ: assert property (@(posedge clock) disable iff (sys_rst)
    op_byte && rx_next == {5'b10110, tdc_read_pkg::ADR_ECHO}
    |=> tx_q[55:48] == $past(cfg_q[1][31:24]) && tx_q[47:0] == '0)
    else $error("echo read wrong");
  AST_IDENT_READ: assert property (@(posedge clock) disable iff (sys_rst)
    op_byte && rx_next == tdc_read_pkg::OP_IDENT
    |=> tx_q[55:48] == $past(cfg_q[0][7:0]) &&
        tx_q[7:0] == $past(cfg_q[6][7:0]))
    else $error("ident bytes out of order");
  AST_ALU_OVERFLOW: assert property (@(posedge clock) disable iff (sys_rst)
    result_wr && result_in.mode == tdc_read_pkg::MEAS_MODE1 &&
    result_in.calibrated && result_in.alu_overflow
    |=> result_q[$past(result_idx)] == 32'hffffffff)
    else $error("overflow result not all ones");
  AST_UNCAL_FORMAT: assert property (@(posedge clock) disable iff (sys_rst)
    result_wr && result_in.mode == tdc_read_pkg::MEAS_MODE1 &&
    !result_in.calibrated
    |=> result_q[$past(result_idx)] == {$past(result_in.raw_count), 16'h0})
    else $error("uncalibrated result misplaced");
  AST_MODE2_PASS: assert property (@(posedge clock) disable iff (sys_rst)
    result_wr && result_in.mode != tdc_read_pkg::MEAS_MODE1
    |=> result_q[$past(result_idx)] == $past(result_in.fixed_value))
    else $error("mode 2 result altered");
  AST_MSB_SHIFT: assert property (@(posedge clock) disable iff (sys_rst)
    fall && reading_q && !op_byte && !ssn
    |=> so == $past(tx_q[54]))
    else $error("output not shifted msb first");
  AST_REFRESH: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == tdc_read_pkg::S_READ && dec_single
    |=> state_q == tdc_read_pkg::S_WRITE && fix_q == $past(dec_data))
    else $error("single error not refreshed");
  AST_END_DONE: assert property (@(posedge clock) disable iff (sys_rst)
    nvm_we && idx_q == tdc_read_pkg::LAST_WORD
    |=> store_done ##1 !store_busy)
    else $error("store action end not signalled");
  AST_BUSY_IGNORE: assert property (@(posedge clock) disable iff (sys_rst)
    store_busy && !store_done |=> $stable(act_q))
    else $error("action restarted while busy");
  AST_FLAGS_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    !store_done |=> $stable({single_q, multi_q, equal_q}))
    else $error("store flags changed outside an action end");
  AST_MULTI_NOT_EQUAL: assert property (@(posedge clock) disable iff (sys_rst)
    store_done && act_q == tdc_read_pkg::ACT_COMPARE && multi_acc_q
    |=> !equal_q && multi_q)
    else $error("equal set despite multi error");
  COV_STATUS_READ: cover property (@(posedge clock)
    op_byte && rx_next == {5'b10110, tdc_read_pkg::ADR_STATUS});
  COV_COMPARE_DONE: cover property (@(posedge clock)
    store_done && act_q == tdc_read_pkg::ACT_COMPARE);
  COV_REFRESH: cover property (@(posedge clock)
    state_q == tdc_read_pkg::S_READ && dec_single);
endmodule

// ==== hw/secded_codec.sv ====
// Hamming single-correct double-detect encoder and decoder for store words.
`timescale 1ns/1ns
module secded_codec (
  input wire logic [tdc_read_pkg::WORD_W-1:0] enc_data,
  output logic [tdc_read_pkg::CODE_W-1:0] enc_code,
  input wire logic [tdc_read_pkg::CODE_W-1:0] dec_code,
  output logic [tdc_read_pkg::WORD_W-1:0] dec_data,
  output logic dec_single,
  output logic dec_multi
);
  logic [tdc_read_pkg::CODE_W-1:0] fixed;
  logic [tdc_read_pkg::CHECK_BITS-1:0] syn;
  logic overall;

  // Data sits at non-power-of-two positions, checks at powers of two.
  always_comb begin
    int d;
    d = 0;
    enc_code = '0;
    for (int p = 1; p < tdc_read_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        enc_code[p] = enc_data[d];
        d++;
      end
    end
    for (int k = 0; k < tdc_read_pkg::CHECK_BITS; k++) begin
      for (int p = 1; p < tdc_read_pkg::CODE_W; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          enc_code[1 << k] = enc_code[1 << k] ^ enc_code[p];
        end
      end
    end
    enc_code[0] = ^enc_code[tdc_read_pkg::CODE_W-1:1];
  end

  // A nonzero syndrome with odd overall parity is one flipped bit.
  always_comb begin
    int d;
    d = 0;
    syn = '0;
    for (int k = 0; k < tdc_read_pkg::CHECK_BITS; k++) begin
      for (int p = 1; p < tdc_read_pkg::CODE_W; p++) begin
        if (((p >> k) & 1) == 1) begin
          syn[k] = syn[k] ^ dec_code[p];
        end
      end
    end
    overall = ^dec_code;
    dec_single = overall;
    dec_multi = !overall && syn != '0;
    fixed = dec_code;
    if (overall && int'(syn) < tdc_read_pkg::CODE_W) begin
      fixed[syn] = !dec_code[syn];
    end
    dec_data = '0;
    for (int p = 1; p < tdc_read_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        dec_data[d] = fixed[p];
        d++;
      end
    end
  end
endmodule

// ==== hw/tdc_read_pkg.sv ====
// Constants and carrier types for the result, status and store register bank.
package tdc_read_pkg;
  localparam int WORD_W = 32;
  localparam int CODE_W = 39;
  localparam int CHECK_BITS = 6;
  localparam int CFG_WORDS = 7;
  localparam int RESULT_COUNT = 4;
  localparam int TX_W = 56;
  localparam int CLOCK_MHZ = 125;
  localparam int STORE_WRITE_US = 300000;
  localparam logic [7:0] OP_READ_BASE = 8'hb0;
  localparam logic [7:0] OP_WRITE_BASE = 8'h80;
  localparam logic [7:0] OP_ADDR_MASK = 8'hf8;
  localparam logic [7:0] OP_IDENT = 8'hb7;
  localparam logic [7:0] OP_SAVE = 8'hc0;
  localparam logic [7:0] OP_LOAD = 8'hf0;
  localparam logic [7:0] OP_COMPARE = 8'hc6;
  localparam logic [2:0] ADR_STATUS = 3'h4;
  localparam logic [2:0] ADR_ECHO = 3'h5;
  localparam logic [2:0] ADR_IDENT = 3'h7;
  localparam logic [2:0] LAST_WORD = 3'h6;
  localparam logic [3:0] BYTES_RESULT = 4'h4;
  localparam logic [3:0] BYTE_CNT_MAX = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int ECHO_REG = 1;
  localparam int ECHO_LSB = 24;
  localparam int DIV_REG = 0;
  localparam int DIV_LSB = 20;
  localparam int IRQ_REG = 6;
  localparam int IRQ_BIT = 21;
  localparam int IDENT_LSB = 0;
  localparam logic [31:0] ALL_ONES = 32'hffffffff;
  localparam logic [15:0] LOW_ZERO = 16'h0000;
  localparam logic [2:0] DIV_BY_1 = 3'h1;
  localparam logic [2:0] DIV_BY_2 = 3'h2;
  localparam logic [2:0] DIV_BY_4 = 3'h4;

  typedef enum logic [1:0] {
    MEAS_MODE1 = 2'h0,
    MEAS_MODE2 = 2'h1,
    MEAS_TEMP = 2'h2
  } meas_mode_t;

  typedef enum logic [1:0] {
    ACT_SAVE = 2'h0,
    ACT_LOAD = 2'h1,
    ACT_COMPARE = 2'h2
  } store_act_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_READ = 4'b0010,
    S_WRITE = 4'b0100,
    S_DONE = 4'b1000
  } store_state_t;

  typedef struct packed {
    meas_mode_t mode;
    logic calibrated;
    logic alu_overflow;
    logic [15:0] raw_count;
    logic [31:0] fixed_value;
  } result_in_t;

  typedef struct packed {
    logic [1:0] result_pointer;
    logic [2:0] hits_ch1;
    logic [2:0] hits_ch2;
    logic tdc_timeout;
    logic precount_timeout;
    logic sensor_open;
    logic sensor_short;
  } front_status_t;
endpackage

// ==== testbench/spi_host_model.sv ====
// Host serial master model for the four-wire link.
`timescale 1ns/1ns
module spi_host_model (
  input wire logic clock,
  input wire logic so,
  input wire logic so_oe_n,
  output logic ssn,
  output logic sck,
  output logic si,
  output logic rd_toggle,
  output logic [55:0] rd_data
);
  initial begin
    ssn = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rd_toggle = 1'b0;
    rd_data = 56'h0;
  end
  task automatic half();
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Shifts one byte out and one byte in, most significant bit first.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      sck = 1'b1;
      half();
      rx[i] = so_oe_n ? 1'bx : so;
      sck = 1'b0;
      half();
    end
  endtask
  // One framed access: opcode, nw write bytes, then nr read bytes.
  task automatic frame(input logic [7:0] op, input logic [31:0] wd,
    input int nw, input int nr);
    logic [7:0] b;
    logic [55:0] rd;
    rd = 56'h0;
    ssn = 1'b0;
    half();
    xbyte(op, b);
    for (int k = 0; k < nw; k++) xbyte(wd[31-8*k -: 8], b);
    for (int k = 0; k < nr; k++) begin
      xbyte(8'h00, b);
      rd = {rd[47:0], b};
    end
    ssn = 1'b1;
    si = ~si;
    rd_data = rd;
    if (nr > 0) rd_toggle = ~rd_toggle;
    half();
  endtask
endmodule

// ==== testbench/tb_result_status_config_store.sv ====
// Self-checking bench for the result, status and store register bank.
`timescale 1ns/1ns
module tb_result_status_config_store;
  logic clock, sys_rst, so, so_oe_n, ssn, sck, si, result_wr, inject_en;
  logic store_busy, store_done, store_irq, rd_toggle;
  logic [1:0] result_idx, refclk_divider;
  logic [2:0] tref_divide_by, inject_idx;
  logic [38:0] inject_mask;
  logic [55:0] rd_data, e;
  logic [31:0] seed, cfg [7];
  tdc_read_pkg::result_in_t result_in;
  tdc_read_pkg::front_status_t front_status;
  logic [55:0] exp_q [$];
  logic [7:0] ops [6] = '{8'hc0, 8'hc6, 8'hc6, 8'hc6, 8'hc6, 8'hf0};
  logic [38:0] msk [6] = '{39'h0, 39'h0, 39'h20, 39'h0, 39'h3, 39'h0};
  logic [2:0] flg [6] = '{3'h0, 3'h4, 3'h5, 3'h4, 3'h2, 3'h2};
  int bad_count = 0;
  int checks_done = 0;
  result_status_config_store #(.WORD_WRITE_CYCLES(4))
    i_result_status_config_store (
    .clock(clock), .sys_rst(sys_rst), .ssn(ssn), .sck(sck), .si(si),
    .so(so), .so_oe_n(so_oe_n), .result_wr(result_wr),
    .result_idx(result_idx), .result_in(result_in),
    .front_status(front_status), .refclk_divider(refclk_divider),
    .tref_divide_by(tref_divide_by), .store_busy(store_busy),
    .store_done(store_done), .store_irq(store_irq), .inject_en(inject_en),
    .inject_idx(inject_idx), .inject_mask(inject_mask));
  spi_host_model i_spi_host_model (.clock(clock), .so(so), .so_oe_n(so_oe_n),
    .ssn(ssn), .sck(sck), .si(si), .rd_toggle(rd_toggle), .rd_data(rd_data));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [55:0] stat(input logic [2:0] f);
    return {40'h0, f, front_status.sensor_short, front_status.sensor_open,
      front_status.precount_timeout, front_status.tdc_timeout,
      front_status.hits_ch2, front_status.hits_ch1, 1'b0,
      front_status.result_pointer};
  endfunction
  task automatic check(input string what, input logic [55:0] x, g);
    checks_done++;
    if (x !== g) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] op, input int n, input logic [55:0] x);
    exp_q.push_back(x);
    i_spi_host_model.frame(op, 32'h0, 0, n);
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1;
    forever begin
      @(rd_toggle);
      check("serial read", exp_q.pop_front(), rd_data);
    end
  end
  initial begin
    #(60000 * 8);
    bad_count++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    {result_wr, inject_en, result_idx, inject_idx, inject_mask} = '0;
    result_in = '0;
    seed = 32'h00012984;
    front_status = seed[11:0];
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    check("reset divider", 56'h1,
      {51'h0, refclk_divider, tref_divide_by});
    check("reset busy", 56'h0, {55'h0, store_busy});
    rd(8'hb4, 2, stat(3'h0));
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      result_in.raw_count = seed[15:0];
      result_in.fixed_value = lfsr(seed);
      result_in.calibrated = k != 0;
      result_in.alu_overflow = k == 1;
      result_in.mode = k == 3 ? tdc_read_pkg::MEAS_TEMP :
        k == 2 ? tdc_read_pkg::MEAS_MODE2 : tdc_read_pkg::MEAS_MODE1;
      e = k == 0 ? {24'h0, seed[15:0], 16'h0} : k == 1 ? 56'hffffffff :
        {24'h0, result_in.fixed_value};
      result_wr = 1'b1;
      result_idx = 2'(k);
      @(posedge clock);
      #1 result_wr = 1'b0;
      rd(8'hb0 | 8'(k), 4, e);
    end
    $display("Test results done");
    for (int k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      cfg[k] = seed;
      cfg[k][21] = k == 6 ? 1'b1 : cfg[k][21];
      for (int d = 0; d < (k == 0 ? 3 : 1); d++) begin
        if (k == 0) cfg[0][21:20] = 2'(d);
        i_spi_host_model.frame(8'h80 | 8'(k), cfg[k], 4, 0);
        if (k == 0) check("divider", 56'(d * 8 + (1 << d)),
          {51'h0, refclk_divider, tref_divide_by});
      end
    end
    rd(8'hb5, 1, {48'h0, cfg[1][31:24]});
    rd(8'hb7, 7, {cfg[0][7:0], cfg[1][7:0], cfg[2][7:0], cfg[3][7:0],
      cfg[4][7:0], cfg[5][7:0], cfg[6][7:0]});
    $display("Test config readback done");
    for (int s = 0; s < 6; s++) begin
      inject_en = |msk[s];
      inject_idx = 3'h3;
      inject_mask = msk[s];
      @(posedge clock);
      #1 inject_en = 1'b0;
      i_spi_host_model.frame(ops[s], 32'h0, 0, 0);
      check("store_busy", 56'h1, {55'h0, store_busy});
      for (int n = 0; n < 400 && store_done !== 1'b1; n++) begin
        @(posedge clock);
        #1;
      end
      check("store_done", 56'h1, {55'h0, store_done});
      check("store_irq", 56'h1, {55'h0, store_irq});
      repeat (2) @(posedge clock);
      #1 check("store_idle", 56'h0, {55'h0, store_busy});
      rd(8'hb4, 2, stat(flg[s]));
    end
    $display("Test store actions done");
    end_sim();
  end
endmodule
